// ==== hw/charger_supervisor.v ====
// Charger gate sequencer, watchdog and protection supervisor
`default_nettype none
`include "charger_supervisor_map.vh"
module charger_supervisor #(
  parameter [31:0] WD_175_CYC     = `WD_175_S * `CLK_HZ,
  parameter [31:0] WD_88_CYC      = `WD_88_S * `CLK_HZ,
  parameter [31:0] WD_44_CYC      = `WD_44_S * `CLK_HZ,
  parameter [31:0] OVP_CYC        = `OVP_CYC,
  parameter [31:0] LOWV_RESET     = `LOWV_RESET_CYC,
  parameter [31:0] LOWV_RESTART   = `LOWV_RESTART_CYC,
  parameter [31:0] INPUT_OC_BLANK = `INPUT_OC_BLANK_CYC
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [15:0] charger_option_word,
  input  wire        option_write,
  input  wire [6:0]  charge_current_setting,
  input  wire        charge_current_write,
  input  wire        charge_voltage_zero,
  input  wire        charge_voltage_write,
  input  wire        cycle_start,
  input  wire        error_above_ramp,
  input  wire        bootstrap_low,
  input  wire        under_current_comparator,
  input  wire        avg_current_below_low,
  input  wire        avg_current_above_high,
  input  wire        battery_low_voltage,
  input  wire        battery_overvoltage,
  input  wire        charge_peak_overcurrent,
  input  wire        input_overcurrent,
  input  wire        thermal_over_hot,
  input  wire        thermal_cool,
  input  wire        short_event,
  input  wire        adapter_detect_low,
  input  wire        supply_undervoltage,
  output reg         high_side_switch,
  output reg         low_side_switch,
  output reg         adapter_switch_on,
  output reg         battery_switch_on,
  output reg         discharge_sink,
  output reg         current_limit_low,
  output reg         soft_start,
  output reg         charging,
  output reg         watchdog_expired,
  output reg         nonsync_mode,
  output reg         input_overcurrent_latch,
  output reg         battery_overvoltage_off,
  output reg         thermal_shutdown,
  output reg         short_latch,
  output reg  [1:0]  peak_threshold_sel,
  output reg         ls_short_threshold_high,
  output reg         hs_short_detect_en,
  output reg  [1:0]  freq_adjust
);
  // Gate states
  localparam [2:0] G_OFF   = 3'h0;
  localparam [2:0] G_HIGH  = 3'h1;
  localparam [2:0] G_DEAD1 = 3'h2;
  localparam [2:0] G_LOW   = 3'h3;
  localparam [2:0] G_DEAD2 = 3'h4;

  // =========================================================================
  // Comparator synchronisers
  wire [15:0] raw = {supply_undervoltage, adapter_detect_low, short_event, thermal_cool,
                     thermal_over_hot, input_overcurrent, charge_peak_overcurrent,
                     battery_overvoltage, battery_low_voltage, avg_current_above_high,
                     avg_current_below_low, under_current_comparator, bootstrap_low,
                     error_above_ramp, cycle_start, 1'b0};
  wire [15:0] s;
  genvar gi;
  generate
    for (gi = 1; gi < 16; gi = gi + 1) begin : g_sync
      sync2 u_sync (.clk(clk), .rst_b(rst_b), .d(raw[gi]), .q(s[gi]));
    end
  endgenerate
  assign s[0] = 1'b0;
  wire cyc_s   = s[1];
  wire err_s   = s[2];
  wire boot_s  = s[3];
  wire uc_s    = s[4];
  wire avlo_s  = s[5];
  wire avhi_s  = s[6];
  wire blow_s  = s[7];
  wire ovp_s   = s[8];
  wire pk_s    = s[9];
  wire ioc_s   = s[10];
  wire hot_s   = s[11];
  wire cool_s  = s[12];
  wire sh_s    = s[13];
  wire adl_s   = s[14];
  wire uv_s    = s[15];

  // Edge memory for cycle start and short events
  reg cyc_d;
  reg sh_d;
  wire cyc_p = cyc_s & ~cyc_d;
  wire sh_p  = sh_s & ~sh_d;

  // =========================================================================
  // Watchdog
  reg  [31:0] wd_cnt;
  wire [1:0]  wd_sel = charger_option_word[`OPT_WD_MSB:`OPT_WD_LSB];
  reg  [31:0] wd_limit;
  // Period decode from the option field
  always @* begin
    if (wd_sel == `WD_44S)
      wd_limit = WD_44_CYC;
    else if (wd_sel == `WD_88S)
      wd_limit = WD_88_CYC;
    else
      wd_limit = WD_175_CYC;
  end
  wire set_write = charge_current_write | charge_voltage_write;

  // Counts only while enabled; register contents are never touched on expiry
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_cnt           <= 32'h0000_0000;
      watchdog_expired <= 1'b0;
    end else begin
      if (set_write) begin
        wd_cnt           <= 32'h0000_0000;
        watchdog_expired <= 1'b0;
      end else if (wd_sel == `WD_OFF) begin
        wd_cnt <= 32'h0000_0000;
        if (option_write)
          watchdog_expired <= 1'b0;
      end else if (!watchdog_expired) begin
        if (wd_cnt >= wd_limit - 32'h0000_0001)
          watchdog_expired <= 1'b1;
        else
          wd_cnt <= wd_cnt + 32'h0000_0001;
      end
    end
  end

  // =========================================================================
  // Input over-current blanking and latch
  reg [31:0] ioc_cnt;
  // Latch clears only on adapter-detect low, which wins over a new trip
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ioc_cnt                 <= 32'h0000_0000;
      input_overcurrent_latch <= 1'b0;
    end else if (adl_s) begin
      ioc_cnt                 <= 32'h0000_0000;
      input_overcurrent_latch <= 1'b0;
    end else if (ioc_s && charger_option_word[`OPT_INPUT_OC_EN]) begin
      if (ioc_cnt >= INPUT_OC_BLANK - 32'h0000_0001)
        input_overcurrent_latch <= 1'b1;
      else
        ioc_cnt <= ioc_cnt + 32'h0000_0001;
    end else begin
      ioc_cnt <= 32'h0000_0000;
    end
  end

  // =========================================================================
  // Short event counter and latch
  reg [2:0] short_cnt;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      short_cnt   <= 3'h0;
      short_latch <= 1'b0;
    end else if (uv_s || adl_s) begin
      short_cnt   <= 3'h0;
      short_latch <= 1'b0;
    end else if (sh_p && !short_latch) begin
      if (short_cnt == `SHORT_LIMIT - 3'h1)
        short_latch <= 1'b1;
      short_cnt <= short_cnt + 3'h1;
    end
  end

  // =========================================================================
  // Battery over-voltage timer; a zero voltage setting masks the comparator
  wire ovp_act = ovp_s & ~charge_voltage_zero;
  reg [31:0] ovp_cnt;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ovp_cnt                 <= 32'h0000_0000;
      battery_overvoltage_off <= 1'b0;
    end else if (!ovp_act) begin
      ovp_cnt <= 32'h0000_0000;
    end else if (ovp_cnt >= OVP_CYC - 32'h0000_0001) begin
      battery_overvoltage_off <= 1'b1;
    end else begin
      ovp_cnt <= ovp_cnt + 32'h0000_0001;
    end
  end

  // =========================================================================
  // Thermal shutdown with hysteresis between the two comparators
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      thermal_shutdown <= 1'b0;
    else if (hot_s)
      thermal_shutdown <= 1'b1;
    else if (cool_s)
      thermal_shutdown <= 1'b0;
  end

  // =========================================================================
  // Battery-low charge reset and restart sequence
  reg [31:0] low_cnt;
  reg        low_reset;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt   <= 32'h0000_0000;
      low_reset <= 1'b0;
    end else if (low_reset) begin
      if (low_cnt >= LOWV_RESTART - 32'h0000_0001) begin
        low_reset <= 1'b0;
        low_cnt   <= 32'h0000_0000;
      end else begin
        low_cnt <= low_cnt + 32'h0000_0001;
      end
    end else if (blow_s) begin
      if (low_cnt >= LOWV_RESET - 32'h0000_0001) begin
        low_reset <= 1'b1;
        low_cnt   <= 32'h0000_0000;
      end else begin
        low_cnt <= low_cnt + 32'h0000_0001;
      end
    end else begin
      low_cnt <= 32'h0000_0000;
    end
  end

  // =========================================================================
  // Charge enable and soft-start request on each re-enable
  wire enable_ok = ~charger_option_word[`OPT_INHIBIT] & ~watchdog_expired &
                   ~input_overcurrent_latch & ~short_latch & ~battery_overvoltage_off &
                   ~thermal_shutdown & ~low_reset;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      charging   <= 1'b0;
      soft_start <= 1'b0;
    end else begin
      charging   <= enable_ok;
      soft_start <= enable_ok & ~charging;
    end
  end

  // =========================================================================
  // Non-synchronous mode with hysteresis
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      nonsync_mode <= 1'b1;
    else if (avlo_s || blow_s)
      nonsync_mode <= 1'b1;
    else if (avhi_s)
      nonsync_mode <= 1'b0;
  end

  // =========================================================================
  // Per-cycle flags: peak over-current block and bootstrap refresh request
  reg pk_block;
  reg refresh;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pk_block <= 1'b0;
      refresh  <= 1'b0;
      cyc_d    <= 1'b0;
      sh_d     <= 1'b0;
    end else begin
      cyc_d <= cyc_s;
      sh_d  <= sh_s;
      if (pk_s)
        pk_block <= 1'b1;
      else if (cyc_p)
        pk_block <= 1'b0;
      if (boot_s)
        refresh <= 1'b1;
      else if (cyc_p)
        refresh <= 1'b0;
    end
  end

  // =========================================================================
  // Gate sequencer; dead states separate every swap of the two switches
  reg [2:0] gstate;
  reg [2:0] next_gstate;
  wire run      = charging & ~ovp_act;
  wire ls_allow = (~nonsync_mode & ~blow_s & ~uc_s) | refresh;
  wire hs_go    = run & err_s & ~pk_block & ~refresh;
  always @* begin
    next_gstate = gstate;
    case (gstate)
      G_OFF: begin
        if (hs_go)
          next_gstate = G_HIGH;
        else if (run && ls_allow && refresh)
          next_gstate = G_LOW;
      end
      G_HIGH: begin
        if (!hs_go || cyc_p)
          next_gstate = G_DEAD1;
      end
      G_DEAD1: begin
        if (run && ls_allow && !cyc_p)
          next_gstate = G_LOW;
        else
          next_gstate = G_OFF;
      end
      G_LOW: begin
        if (cyc_p || !run || !ls_allow)
          next_gstate = G_DEAD2;
      end
      G_DEAD2: begin
        next_gstate = G_OFF;
      end
      default: begin
        next_gstate = G_OFF;
      end
    endcase
  end

  // Gates come from flip-flops, so only one state drives either gate
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gstate           <= G_OFF;
      high_side_switch <= 1'b0;
      low_side_switch  <= 1'b0;
    end else begin
      gstate           <= next_gstate;
      high_side_switch <= (next_gstate == G_HIGH);
      low_side_switch  <= (next_gstate == G_LOW);
    end
  end

  // =========================================================================
  // Status, path switches and option decodes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adapter_switch_on       <= 1'b0;
      battery_switch_on       <= 1'b1;
      discharge_sink          <= 1'b0;
      current_limit_low       <= 1'b0;
      peak_threshold_sel      <= `OCP_6A;
      ls_short_threshold_high <= 1'b0;
      hs_short_detect_en      <= 1'b0;
      freq_adjust             <= 2'h0;
    end else begin
      adapter_switch_on <= ~input_overcurrent_latch & ~short_latch & ~adl_s;
      battery_switch_on <= short_latch | input_overcurrent_latch | adl_s;
      discharge_sink    <= ovp_act;
      current_limit_low <= blow_s;
      if (charge_current_setting >= `CUR_HIGH_LIMIT)
        peak_threshold_sel <= `OCP_12A;
      else if (charge_current_setting >= `CUR_MID_LIMIT)
        peak_threshold_sel <= `OCP_9A;
      else
        peak_threshold_sel <= `OCP_6A;
      ls_short_threshold_high <= charger_option_word[`OPT_LS_SHORT_HI];
      hs_short_detect_en      <= charger_option_word[`OPT_HS_SHORT_EN];
      // Bit 1 requests a shift, bit 0 gives its direction
      freq_adjust <= {charger_option_word[`OPT_FREQ_ADJ_EN],
                      charger_option_word[`OPT_FREQ_ADJ_UP]};
    end
  end
endmodule
`default_nettype wire

// ==== hw/charger_supervisor_map.vh ====
// Constants for the charger switch and fault supervisor
// Operation
// - Suspend charge when no voltage or current write arrives within the watchdog period.
// - Two-bit option field disables watchdog or selects 44, 88 or 175 seconds.
// - After timeout a setting write restarts the watchdog and resumes charging.
// - After timeout, writing the field to disable the watchdog also resumes charging.
// - Low bootstrap voltage starts a refresh by turning on the low-side switch.
// - High side on while error exceeds ramp, then low side until ramp reset.
// - Every gate transition inserts dead time with both switches off.
// - Under-current comparator turns the low-side switch off each cycle.
// - Low average current or low battery enters non-synchronous mode, refresh only.
// - Average current above upper threshold leaves non-synchronous mode.
// - Input over-current beyond blanking latches adapter switches off until detect low.
// - Option bit enables or disables the input over-current latch-off.
// - Peak charge over-current blocks high side for rest of the cycle.
// - One of three peak thresholds is chosen from the charge-current setting.
// - Battery over-voltage blocks switches, enables sink, disables charger after 30 ms.
// - Zero charge-voltage setting never counts as battery over-voltage.
// - Low battery resets charge after 1 ms, restarts after further 4-5 ms.
// - While battery low, limit current and keep low side off except refresh.
// - Over-temperature stops converter until cool, then soft-start resumes.
// - One option bit enables frequency adjust, another selects lower or higher.
// - Seventh short event latches charger off, opens adapter, closes battery switch.
// - Option bits select low-side short threshold and high-side short detect.
`ifndef CHARGER_SUPERVISOR_MAP_VH
`define CHARGER_SUPERVISOR_MAP_VH

// ==========================================================================
// Option word fields
`define OPT_INHIBIT         0
`define OPT_INPUT_OC_EN     1
`define OPT_LS_SHORT_HI     7
`define OPT_HS_SHORT_EN     8
`define OPT_FREQ_ADJ_EN     9
`define OPT_FREQ_ADJ_UP     10
`define OPT_WD_LSB          13
`define OPT_WD_MSB          14
`define WD_OFF              2'h0
`define WD_44S              2'h1
`define WD_88S              2'h2

// ==========================================================================
// Times and derived cycle counts at 10 MHz
`define CLK_HZ              10000000
`define WD_44_S             44
`define WD_88_S             88
`define WD_175_S            175
`define OVP_LIMIT_MS        30
`define LOWV_RESET_MS       1
`define LOWV_RESTART_MS     5
`define INPUT_OC_BLANK_US   4200
`define DEAD_NS             100
`define CLK_NS              100
`define MS_CYC              (`CLK_HZ / 1000)
`define OVP_CYC             (`OVP_LIMIT_MS * `MS_CYC)
`define LOWV_RESET_CYC      (`LOWV_RESET_MS * `MS_CYC)
`define LOWV_RESTART_CYC    (`LOWV_RESTART_MS * `MS_CYC)
`define INPUT_OC_BLANK_CYC  (`INPUT_OC_BLANK_US * (`CLK_HZ / 1000000))
`define DEAD_CYC            ((`DEAD_NS + `CLK_NS - 1) / `CLK_NS)
`define SHORT_LIMIT         3'h7

// ==========================================================================
// Peak over-current threshold selection from charge-current setting
`define CUR_MID_LIMIT       7'h20
`define CUR_HIGH_LIMIT      7'h40
`define OCP_6A              2'h0
`define OCP_9A              2'h1
`define OCP_12A             2'h2

`endif

// ==== hw/sync2.v ====
// Two-flip-flop synchroniser for one asynchronous level
`default_nettype none
module sync2 (
  input  wire clk,
  input  wire rst_b,
  input  wire d,
  output reg  q
);
  reg meta;

  // =========================================================================
  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// ==== tb/charger_supervisor_properties.sv ====
// Concurrent checks on the supervisor's gate and protection outputs
`default_nettype none
module charger_supervisor_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bootstrap_low,
  input wire logic high_side_switch,
  input wire logic low_side_switch,
  input wire logic adapter_switch_on,
  input wire logic battery_switch_on,
  input wire logic discharge_sink,
  input wire logic soft_start,
  input wire logic charging,
  input wire logic watchdog_expired,
  input wire logic nonsync_mode,
  input wire logic input_overcurrent_latch,
  input wire logic battery_overvoltage_off,
  input wire logic thermal_shutdown,
  input wire logic short_latch
);
  // ==========================================================================
  // One domain, so one clock and one disable for all checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Gate sequencing
  AST_NO_OVERLAP: assert property (!(high_side_switch && low_side_switch))
    else $error("both gates on together");
  AST_LS_GAP: assert property ($rose(low_side_switch) |-> !$past(high_side_switch))
    else $error("low side on without dead time");
  AST_HS_GAP: assert property ($rose(high_side_switch) |-> !$past(low_side_switch))
    else $error("high side on without dead time");
  AST_HS_TO_LS: assert property ($fell(high_side_switch) |-> !low_side_switch)
    else $error("low side on at high side release");
  // Refresh lag covers sync, decision and a possible dead cycle
  AST_REFRESH_ONLY: assert property (nonsync_mode && $rose(low_side_switch) |->
    $past(bootstrap_low, 2) || $past(bootstrap_low, 3) || $past(bootstrap_low, 4) ||
    $past(bootstrap_low, 5) || $past(bootstrap_low, 6))
    else $error("low side on in non-sync mode without refresh");

  // ==========================================================================
  // Protection responses; two samples (three for thermal) allow for a clear landing with the output
  AST_WD_SUSPEND: assert property (watchdog_expired [*2] |-> !charging)
    else $error("charging while watchdog expired");
  AST_SOFT_START: assert property ($rose(charging) |-> ##[0:1] soft_start)
    else $error("charge start without soft start");
  AST_OVP_OFF: assert property (battery_overvoltage_off |=>
    !high_side_switch && !low_side_switch && !charging)
    else $error("switching after over-voltage disable");
  AST_SINK_BLOCK: assert property (discharge_sink [*2] |->
    !high_side_switch && !low_side_switch)
    else $error("switching while sink on");
  AST_INOC_OPEN: assert property (input_overcurrent_latch [*2] |-> !adapter_switch_on)
    else $error("adapter switch on while latched");
  AST_SHORT_OFF: assert property (short_latch [*2] |->
    !adapter_switch_on && battery_switch_on && !charging)
    else $error("short latch response wrong");
  AST_THERMAL_OFF: assert property (thermal_shutdown [*3] |->
    !high_side_switch && !charging)
    else $error("converter running while hot");

  cover property (nonsync_mode && $rose(low_side_switch));
  cover property ($rose(short_latch));
  cover property ($rose(watchdog_expired));
endmodule

bind charger_supervisor charger_supervisor_properties u_charger_supervisor_properties (
  .clk(clk), .rst_b(rst_b), .bootstrap_low(bootstrap_low),
  .high_side_switch(high_side_switch), .low_side_switch(low_side_switch),
  .adapter_switch_on(adapter_switch_on), .battery_switch_on(battery_switch_on),
  .discharge_sink(discharge_sink), .soft_start(soft_start), .charging(charging),
  .watchdog_expired(watchdog_expired), .nonsync_mode(nonsync_mode),
  .input_overcurrent_latch(input_overcurrent_latch),
  .battery_overvoltage_off(battery_overvoltage_off),
  .thermal_shutdown(thermal_shutdown), .short_latch(short_latch));
`default_nettype wire

// ==== tb/power_stage_model.sv ====
// Power stage and sense comparator model facing the low-side gate output
`default_nettype none
module power_stage_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] duty,
  input  wire logic       discontinuous_conduction,
  input  wire logic       ls,
  output logic            cycle_start,
  output logic            error_above_ramp,
  output logic            under_current_comparator,
  output logic            bootstrap_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ramp;
  logic [7:0] boot;

  // ==========================================================================
  // Ramp of 20 clocks; bootstrap charge drains until the low side conducts
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp <= 8'h00;
      boot <= 8'h00;
    end else begin
      ramp <= (ramp == 8'h13) ? 8'h00 : ramp + 8'h01;
      boot <= ls ? 8'h00 : ((boot == 8'hff) ? boot : boot + 8'h01);
    end
  end

  // Comparator levels; inductor current reaches zero early in discontinuous conduction
  assign cycle_start              = ramp < 8'h02;
  assign error_above_ramp         = duty > ramp;
  assign under_current_comparator = discontinuous_conduction && (ramp >= duty + 8'h02);
  assign bootstrap_low            = boot > 8'h3c;
endmodule
`default_nettype wire

// ==== tb/charger_supervisor_tb.sv ====
// Self-checking bench for the charger supervisor
`default_nettype none
module charger_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Stimulus, observed outputs and tallies
  logic        clk = 0, rst_b = 0, ow = 0, cw = 0, vz = 0, vw = 0, dcon = 0;
  logic        alo = 0, ahi = 0, blv = 0, bov = 0, pk = 0, ioc = 0;
  logic        hot = 0, cool = 0, sev = 0, adl = 0, suv = 0, ls_q = 0;
  logic [15:0] opt = 16'h6002;
  logic [6:0]  cur = 7'h10;
  logic [7:0]  duty = 8'h0a;
  logic [6:0]  ct[5] = '{7'h1f, 7'h20, 7'h3f, 7'h40, 7'h7f};
  logic [1:0]  ps[5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  wire         cs, ear, bl, uc, hs, ls, acs, bsw, dsk, cll, ss, chg;
  wire         wde, nsm, iol, ovo, tsd, shl, lsh, hse;
  wire  [1:0]  pts, fa;
  int          error_cnt = 0, tests_run = 0, ls_rise = 0, ls_on = 0, hs_on = 0;
  int          per[4] = '{0, 50, 100, 200};
  int          a, b, l1, h1;

  charger_supervisor #(.WD_175_CYC(200), .WD_88_CYC(100), .WD_44_CYC(50), .OVP_CYC(30),
    .LOWV_RESET(10), .LOWV_RESTART(50), .INPUT_OC_BLANK(42)) u_charger_supervisor (
    .clk(clk), .rst_b(rst_b), .charger_option_word(opt), .option_write(ow),
    .charge_current_setting(cur), .charge_current_write(cw), .charge_voltage_zero(vz),
    .charge_voltage_write(vw), .cycle_start(cs), .error_above_ramp(ear),
    .bootstrap_low(bl), .under_current_comparator(uc), .avg_current_below_low(alo),
    .avg_current_above_high(ahi), .battery_low_voltage(blv), .battery_overvoltage(bov),
    .charge_peak_overcurrent(pk), .input_overcurrent(ioc), .thermal_over_hot(hot),
    .thermal_cool(cool), .short_event(sev), .adapter_detect_low(adl),
    .supply_undervoltage(suv), .high_side_switch(hs), .low_side_switch(ls),
    .adapter_switch_on(acs), .battery_switch_on(bsw), .discharge_sink(dsk),
    .current_limit_low(cll), .soft_start(ss), .charging(chg), .watchdog_expired(wde),
    .nonsync_mode(nsm), .input_overcurrent_latch(iol), .battery_overvoltage_off(ovo),
    .thermal_shutdown(tsd), .short_latch(shl), .peak_threshold_sel(pts),
    .ls_short_threshold_high(lsh), .hs_short_detect_en(hse), .freq_adjust(fa));

  power_stage_model u_power_stage_model (.clk(clk), .rst_b(rst_b), .duty(duty),
    .discontinuous_conduction(dcon), .ls(ls), .cycle_start(cs), .error_above_ramp(ear),
    .under_current_comparator(uc), .bootstrap_low(bl));

  // ==========================================================================
  // Clock and gate activity tallies, read as differences so nothing is cleared
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (ls && !ls_q) ls_rise++;
    if (ls) ls_on++;
    if (hs) hs_on++;
    ls_q <= ls;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [1:0] g, input logic [1:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %b expected %b", $time, g, e);
    end
  endtask
  task automatic wr_opt(input logic [15:0] v);
    opt <= v;
    ow <= 1'b1;
    cyc(1);
    ow <= 1'b0;
  endtask
  // Host write of a charge setting; volt picks the voltage strobe
  task automatic wr_set(input logic [6:0] v, input logic volt);
    cur <= v;
    cw <= !volt;
    vw <= volt;
    cyc(1);
    cw <= 1'b0;
    vw <= 1'b0;
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Whole sequence needs about 2700 cycles
  initial begin
    #1_000_000;
    error_cnt++;
    complete_run();
  end

  initial begin
    cyc(4);
    chk({bsw, nsm}, 2'b11);
    rst_b <= 1'b1;
    cyc(4);
    chk(chg, 1'b1);
    cyc(180);
    wr_set(7'h10, 1'b0);
    cyc(180);
    chk(chg, 1'b1);
    cyc(40);
    chk({wde, chg}, 2'b10);
    for (int c = 1; c < 4; c++) begin
      wr_set(7'h10, 1'b1);
      wr_opt({1'b0, c[1:0], 13'h0002});
      cyc(per[c] - 12);
      chk({wde, chg}, 2'b01);
      cyc(20);
      chk({wde, chg}, 2'b10);
    end
    wr_opt(16'h0002);
    cyc(5);
    chk({wde, chg}, 2'b01);
    cyc(250);
    chk(chg, 1'b1);
    // Synchronous switching, then zero-current cut-off, then peak limit
    ahi <= 1'b1;
    cyc(6);
    chk(nsm, 1'b0);
    a = ls_rise;
    b = ls_on;
    h1 = hs_on;
    cyc(200);
    l1 = ls_on - b;
    h1 = hs_on - h1;
    chk(ls_rise - a >= 8, 1'b1);
    // A wider error window must lengthen the high-side share of each cycle
    duty <= 8'h0e;
    a = hs_on;
    cyc(200);
    chk(hs_on - a > h1, 1'b1);
    duty <= 8'h0a;
    dcon <= 1'b1;
    cyc(4);
    b = ls_on;
    cyc(200);
    chk(ls_on - b < l1 - 20, 1'b1);
    dcon <= 1'b0;
    pk <= 1'b1;
    a = hs_on;
    cyc(200);
    chk(hs_on - a < h1 / 2, 1'b1);
    pk <= 1'b0;
    ahi <= 1'b0;
    alo <= 1'b1;
    cyc(6);
    chk(nsm, 1'b1);
    a = ls_rise;
    cyc(400);
    chk(ls_rise - a >= 2 && ls_rise - a <= 8, 1'b1);
    foreach (ct[i]) begin
      wr_set(ct[i], 1'b0);
      cyc(3);
      chk(pts, ps[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr_opt({5'h00, i[1], i[0], i[1], i[0], 7'h02});
      cyc(3);
      chk(fa, {i[0], i[1]});
      chk({hse, lsh}, {i[1], i[0]});
    end
    wr_opt(16'h0000);
    ioc <= 1'b1;
    cyc(60);
    chk(iol, 1'b0);
    ioc <= 1'b0;
    cyc(4);
    wr_opt(16'h0002);
    ioc <= 1'b1;
    cyc(30);
    chk(iol, 1'b0);
    cyc(30);
    chk({iol, acs}, 2'b10);
    ioc <= 1'b0;
    adl <= 1'b1;
    cyc(6);
    chk(iol, 1'b0);
    adl <= 1'b0;
    vz <= 1'b1;
    bov <= 1'b1;
    cyc(40);
    chk({dsk, ovo}, 2'b00);
    vz <= 1'b0;
    cyc(6);
    chk({dsk, hs | ls}, 2'b10);
    bov <= 1'b0;
    cyc(6);
    chk(dsk, 1'b0);
    bov <= 1'b1;
    cyc(40);
    chk({ovo, chg}, 2'b10);
    bov <= 1'b0;
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    cyc(4);
    chk({ovo, chg}, 2'b01);
    blv <= 1'b1;
    cyc(6);
    chk({cll, nsm}, 2'b11);
    cyc(10);
    chk(chg, 1'b0);
    cyc(34);
    chk(chg, 1'b0);
    // Release before the restart so the low-voltage timer does not re-arm
    blv <= 1'b0;
    cyc(20);
    chk(chg, 1'b1);
    hot <= 1'b1;
    cyc(6);
    chk({tsd, chg}, 2'b10);
    hot <= 1'b0;
    cyc(10);
    chk(tsd, 1'b1);
    cool <= 1'b1;
    cyc(6);
    chk({tsd, chg}, 2'b01);
    cool <= 1'b0;
    for (int i = 1; i <= 7; i++) begin
      sev <= 1'b1;
      cyc(3);
      sev <= 1'b0;
      cyc(3);
      chk(shl, 2'(i / 7));
    end
    chk({acs, bsw}, 2'b01);
    suv <= 1'b1;
    cyc(6);
    chk(shl, 1'b0);
    suv <= 1'b0;
    cyc(10);
    complete_run();
  end
endmodule
`default_nettype wire
